// [design/eilac_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eilac_cfg.svh"
// Function
// - Qualify index when A and B match their programmed polarities.
// - Index channel active level set by index-polarity bit.
// - Ignore-quadrature bit drops A and B from index qualification.
// - Continuous-clear repeats index action while qualified index stays active.
// - Single-clear arms detection; act only on next qualified index event.
// - Rising-edge bit triggers on index becoming active, no level control.
// - Falling-edge bit triggers on index becoming inactive, no level control.
// - Index event latches position; clear-counter bit also zeroes position.
// - Compare-source bit picks ramp position (0) or encoder position (1).
// - Decimal-divisor bit picks n/65536 or n/10000 increment scaling.
// - Vector encoder constant is signed six-dot-six fixed point.
// - Vector constant zero, the reset value, switches vector control off.
// - Readable, writable 8-bit vector angle, software-initialised to table bits.
// - Resolution field picks table address bits 12..5, 11..4, 9..2, 7..0.
// - Load-angle field limits to 64, 72, 80 or 88 of 256.
// - Load-angle limit is applied symmetrically in both directions.
// - Index event sets status flag; status read clears it.
// - Each encoder count adds or subtracts the accumulation constant.
module eilac_top
  import eilac_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire eilac_req_t  reg_req,
  output var  logic [31:0] reg_rdata,
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        enc_n,
  input  wire logic [31:0] ramp_position,
  input  wire logic [31:0] compare_position,
  input  wire logic [12:0] microstep_adr,
  output var  logic        position_match_output,
  output var  logic        index_action,
  output var  logic        load_lead_limit,
  output var  logic        load_lag_limit
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Fractions stay in 0..9999 in decimal mode, so a carry never skips a step.
  function automatic logic [47:0] step_pos(input logic [47:0] p, input logic [31:0] c,
                                           input logic up, input logic dec);
    logic [16:0] f;
    logic [31:0] i;
    f = 17'h0_0000;
    i = 32'h0000_0000;
    if (!dec) begin
      step_pos = up ? p + {{16{c[31]}}, c} : p - {{16{c[31]}}, c};
    end else begin
      i = {{16{c[31]}}, c[31:16]};
      if (up) begin
        f = {1'b0, p[15:0]} + {1'b0, c[15:0]};
        if (f >= `EILAC_DEC_MOD) begin
          f = f - `EILAC_DEC_MOD;
          i = i + 32'h0000_0001;
        end
        step_pos = {p[47:16] + i, f[15:0]};
      end else begin
        f = {1'b0, p[15:0]} - {1'b0, c[15:0]};
        if (f[16]) begin
          f = f + `EILAC_DEC_MOD;
          i = i + 32'h0000_0001;
        end
        step_pos = {p[47:16] - i, f[15:0]};
      end
    end
  endfunction : step_pos

  // ------------------------------------------------------------
  // Pin synchronisers and quadrature decode
  // ------------------------------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_d;
  // The chain keeps sampling through reset, so a pin already high at release
  // is not taken for a fresh transition and the counter starts clean.
  always_ff @(posedge sys_clk) begin
    pin_s1 <= {enc_n, enc_b, enc_a};
    pin_s2 <= pin_s1;
    pin_d  <= pin_s2;
  end
  wire a_s   = pin_s2[0];
  wire b_s   = pin_s2[1];
  wire n_s   = pin_s2[2];
  wire cnt   = (a_s ^ pin_d[0]) ^ (b_s ^ pin_d[1]);
  wire cnt_up = pin_d[0] ^ b_s;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  eilac_cfg_t  cfg;
  eilac_vsel_t vsel;
  logic [31:0] enc_const;
  logic [47:0] enc_pos;
  logic [31:0] enc_latch;
  logic        index_flag;
  logic [11:0] venc_const;
  logic [13:0] venc_acc;
  eilac_arm_t  arm;
  logic        qual_d;

  wire wr_hit_const  = reg_req.wr && reg_req.addr == `EILAC_ADR_ENC_CONST;
  wire wr_hit_pos    = reg_req.wr && reg_req.addr == `EILAC_ADR_ENC_POS;
  wire wr_hit_cfg    = reg_req.wr && reg_req.addr == `EILAC_ADR_ENC_CFG;
  wire wr_hit_vconst = reg_req.wr && reg_req.addr == `EILAC_ADR_VENC_CONST;
  wire wr_hit_vang   = reg_req.wr && reg_req.addr == `EILAC_ADR_VENC_ANGLE;
  wire wr_hit_vsel   = reg_req.wr && reg_req.addr == `EILAC_ADR_VENC_SEL;
  wire rd_status     = reg_req.rd && reg_req.addr == `EILAC_ADR_ENC_STATUS;
  wire eilac_cfg_t cfg_wr = reg_req.wdata[13:0];

  // ------------------------------------------------------------
  // Index qualification
  // ------------------------------------------------------------
  wire n_active = (n_s == cfg.pol_n);
  wire ab_match = (a_s == cfg.pol_a) && (b_s == cfg.pol_b);
  wire qual     = n_active && (cfg.skip_quadrature_qualify || ab_match);
  wire rise_ev  = cfg.pos_edge && qual && !qual_d;
  wire fall_ev  = cfg.neg_edge && !qual && qual_d;
  wire edge_mode = cfg.pos_edge || cfg.neg_edge;
  wire index_ev = edge_mode ? (rise_ev || fall_ev) : qual;
  wire act      = index_ev && (cfg.clr_cont || arm == EILAC_ARMED);
  wire [47:0] pos_stepped = step_pos(enc_pos, enc_const, cnt_up, cfg.dec_div);

  // ------------------------------------------------------------
  // Vector control
  // ------------------------------------------------------------
  wire       venc_on  = venc_const != 12'h000;
  wire [13:0] venc_step = {{2{venc_const[11]}}, venc_const};
  wire [7:0] venc_angle = venc_acc[13:6];
  wire [7:0] table_angle =
    vsel.res_sel == 2'h0 ? microstep_adr[12:5] :
    vsel.res_sel == 2'h1 ? microstep_adr[11:4] :
    vsel.res_sel == 2'h2 ? microstep_adr[9:2] : microstep_adr[7:0];
  wire [7:0] load_lim =
    vsel.load_sel == 2'h0 ? `EILAC_LIM_00 :
    vsel.load_sel == 2'h1 ? `EILAC_LIM_01 :
    vsel.load_sel == 2'h2 ? `EILAC_LIM_10 : `EILAC_LIM_11;
  wire [7:0] load_diff = table_angle - venc_angle;
  wire       lead_hit  = venc_on && !load_diff[7] && load_diff >= load_lim;
  wire       lag_hit   = venc_on && load_diff[7] && (8'h00 - load_diff) >= load_lim;

  // ------------------------------------------------------------
  // Configuration and constants
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg        <= '0;
      vsel       <= '0;
      enc_const  <= `EILAC_ENC_CONST_RST;
      venc_const <= 12'h000;
    end else begin
      if (wr_hit_cfg) begin
        cfg      <= reg_req.wdata[13:0];
        cfg.rsvd <= 3'h0;
      end
      if (wr_hit_vsel) begin
        vsel <= reg_req.wdata[9:0];
      end
      if (wr_hit_const) begin
        enc_const <= reg_req.wdata;
      end
      if (wr_hit_vconst) begin
        venc_const <= reg_req.wdata[11:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Position counter, latch, arming and status
  // ------------------------------------------------------------
  // Clearing wins over a count in the same cycle so the index lands on zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enc_pos   <= 48'h0000_0000_0000;
      enc_latch <= 32'h0000_0000;
      arm       <= EILAC_DISARMED;
      qual_d    <= 1'b0;
    end else begin
      qual_d <= qual;
      if (act) begin
        enc_latch <= enc_pos[47:16];
      end
      if (act && cfg.clr_pos) begin
        enc_pos <= 48'h0000_0000_0000;
      end else if (wr_hit_pos) begin
        enc_pos <= {reg_req.wdata, 16'h0000};
      end else if (cnt) begin
        enc_pos <= pos_stepped;
      end
      if (wr_hit_cfg && cfg_wr.clr_once) begin
        arm <= EILAC_ARMED;
      end else if (act) begin
        arm <= EILAC_DISARMED;
      end
    end
  end

  // The status read and a fresh event in one cycle keep the flag set.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      index_flag <= 1'b0;
    end else if (act) begin
      index_flag <= 1'b1;
    end else if (rd_status) begin
      index_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      venc_acc <= 14'h0000;
    end else if (wr_hit_vang) begin
      venc_acc <= {reg_req.wdata[7:0], 6'h00};
    end else if (cnt && venc_on) begin
      venc_acc <= cnt_up ? venc_acc + venc_step : venc_acc - venc_step;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  wire [31:0] cmp_src = cfg.cmp_enc ? enc_pos[47:16] : ramp_position;
  wire [31:0] rd_mux =
    reg_req.addr == `EILAC_ADR_ENC_POS    ? enc_pos[47:16] :
    reg_req.addr == `EILAC_ADR_ENC_STATUS ? {31'h0, index_flag} :
    reg_req.addr == `EILAC_ADR_ENC_LATCH  ? enc_latch :
    reg_req.addr == `EILAC_ADR_VENC_ANGLE ? {24'h00_0000, venc_angle} :
    32'h0000_0000;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata             <= 32'h0000_0000;
      position_match_output <= 1'b0;
      index_action          <= 1'b0;
      load_lead_limit       <= 1'b0;
      load_lag_limit        <= 1'b0;
    end else begin
      reg_rdata             <= reg_req.rd ? rd_mux : 32'h0000_0000;
      position_match_output <= cmp_src == compare_position;
      index_action          <= act;
      load_lead_limit       <= lead_hit;
      load_lag_limit        <= lag_hit;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence idx_act_s;
    act && cfg.clr_pos && !wr_hit_cfg;
  endsequence
  sequence pos_zero_s;
    enc_pos == 48'h0000_0000_0000;
  endsequence

  index_clears_pos_a: assert property (@(posedge sys_clk) disable iff (rst)
    idx_act_s |=> pos_zero_s) else $error("index did not clear position");
  latch_copies_a: assert property (@(posedge sys_clk) disable iff (rst)
    act |=> enc_latch == $past(enc_pos[47:16])) else $error("latch missed position");
  flag_sets_a: assert property (@(posedge sys_clk) disable iff (rst)
    act |=> index_flag) else $error("index flag not set");
  flag_read_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_status && !act |=> !index_flag) else $error("status read left flag set");
  single_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    act && !cfg.clr_cont && !wr_hit_cfg |=> !act) else $error("single clear acted twice");
  edge_no_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.pos_edge && !cfg.neg_edge && qual_d |-> !index_ev) else $error("level trigger in edge mode");
  cont_repeat_a: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.clr_cont && !edge_mode && qual |-> act) else $error("continuous clear skipped");
  compare_src_a: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg.cmp_enc && ramp_position == compare_position |=> position_match_output)
    else $error("compare on ramp position failed");
  venc_off_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !venc_on && !wr_hit_vang |=> $stable(venc_acc)) else $error("vector angle moved while off");
  load_sym_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_lead_limit |-> !load_lag_limit) else $error("both load limits active");

endmodule : eilac_top
`default_nettype wire

// [shared/eilac_cfg.svh]
`ifndef EILAC_CFG_SVH
`define EILAC_CFG_SVH
`define EILAC_ADR_ENC_CONST   7'h10
`define EILAC_ADR_ENC_POS     7'h11
`define EILAC_ADR_ENC_CFG     7'h12
`define EILAC_ADR_ENC_STATUS  7'h13
`define EILAC_ADR_ENC_LATCH   7'h14
`define EILAC_ADR_VENC_CONST  7'h17
`define EILAC_ADR_VENC_ANGLE  7'h18
`define EILAC_ADR_VENC_SEL    7'h19
`define EILAC_ENC_CONST_RST   32'h0001_0000
`define EILAC_DEC_MOD         17'h0_2710
`define EILAC_LIM_00          8'h40
`define EILAC_LIM_01          8'h48
`define EILAC_LIM_10          8'h50
`define EILAC_LIM_11          8'h58
`endif

// [shared/eilac_pkg.sv]
package eilac_pkg;
  typedef struct packed {
    logic       dec_div;
    logic       cmp_enc;
    logic [2:0] rsvd;
    logic       clr_pos;
    logic       neg_edge;
    logic       pos_edge;
    logic       clr_once;
    logic       clr_cont;
    logic       skip_quadrature_qualify;
    logic       pol_n;
    logic       pol_b;
    logic       pol_a;
  } eilac_cfg_t;
  typedef struct packed {
    logic [1:0] load_sel;
    logic [5:0] rsvd;
    logic [1:0] res_sel;
  } eilac_vsel_t;
  typedef struct packed {
    logic [6:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } eilac_req_t;
  typedef enum logic [1:0] {EILAC_DISARMED, EILAC_ARMED} eilac_arm_t;
endpackage : eilac_pkg

// [dv/eilac_enc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Quadrature encoder with index channel
// ------------------------------------------------------------
module eilac_enc_model (
  input  wire logic sys_clk,
  output var  logic enc_a,
  output var  logic enc_b,
  output var  logic enc_n
);
  int unsigned phase;
  initial begin
    phase = 0;
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_n = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : hold
  // Gray order 00, 01, 11, 10 counts up; each state stands four clocks,
  // since the synchroniser needs three to see it.
  task automatic step(input int n);
    repeat (n) begin
      phase = (phase + 1) % 4;
      enc_a = phase[1];
      enc_b = phase[1] ^ phase[0];
      hold(4);
    end
  endtask : step
  task automatic set_n(input logic lvl);
    enc_n = lvl;
    hold(6);
  endtask : set_n
  task automatic pulse(input logic lvl);
    set_n(lvl);
    set_n(~lvl);
  endtask : pulse
endmodule : eilac_enc_model
`default_nettype wire

// [dv/eilac_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module eilac_top_tb_top
  import eilac_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  eilac_req_t  reg_req;
  logic [31:0] reg_rdata;
  wire logic   enc_a;
  wire logic   enc_b;
  wire logic   enc_n;
  logic [31:0] ramp_position;
  logic [31:0] compare_position;
  logic [12:0] microstep_adr;
  logic        position_match_output;
  logic        index_action;
  logic        load_lead_limit;
  logic        load_lag_limit;
  int          err_total;
  int          checked;
  int          act_cnt;
  logic [7:0]  lim;
  logic [7:0]  ang;
  logic [31:0] ecfg [4] = '{32'h5C, 32'h9C, 32'hDC, 32'h58};
  int          eexp [4] = '{1, 1, 2, 1};
  int          sh   [4] = '{5, 4, 2, 0};
  eilac_top i_eilac_top (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
    .ramp_position(ramp_position), .compare_position(compare_position),
    .microstep_adr(microstep_adr), .position_match_output(position_match_output),
    .index_action(index_action), .load_lead_limit(load_lead_limit),
    .load_lag_limit(load_lag_limit));
  eilac_enc_model i_eilac_enc_model (.sys_clk(sys_clk), .enc_a(enc_a), .enc_b(enc_b),
    .enc_n(enc_n));
  // ------------------------------------------------------------
  // Clock, monitor and access tasks
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (index_action === 1'b1) act_cnt++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // Strobes drop for a cycle between requests so no signal is driven twice at once.
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc(1);
    reg_req.wr = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [31:0] e, input string m);
    reg_req = '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    cyc(1);
    reg_req.rd = 1'b0;
    check(reg_rdata, e, m);
    cyc(1);
  endtask : rdchk
  task automatic match(input logic e);
    cyc(3);
    check(32'(position_match_output), 32'(e), "compare");
  endtask : match
  task automatic done(input string t);
    $display("Test %s finished, mismatches so far %0d", t, err_total);
  endtask : done
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #400000;
    err_total++;
    $display("Error at %0t: run limit reached", $time);
    give_verdict();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_req = '0;
    ramp_position = 32'h0000_1234;
    compare_position = 32'h0000_1234;
    microstep_adr = 13'h0C00;
    err_total = 0;
    checked = 0;
    act_cnt = 0;
    cyc(2);
    rst = 1'b0;
    rdchk(7'h11, 32'h0, "position reset");
    rdchk(7'h14, 32'h0, "latch reset");
    rdchk(7'h13, 32'h0, "status reset");
    rdchk(7'h12, 32'h0, "write-only config");
    rdchk(7'h05, 32'h0, "unmapped");
    check(32'(load_lead_limit), 32'h0, "off lead");
    check(32'(load_lag_limit), 32'h0, "off lag");
    wr(7'h18, 32'h0000_00A5);
    rdchk(7'h18, 32'h0000_00A5, "angle");
    i_eilac_enc_model.step(4);
    cyc(4);
    rdchk(7'h11, 32'h4, "count up");
    done("reset_count");
    wr(7'h12, 32'h0000_012D);
    act_cnt = 0;
    i_eilac_enc_model.pulse(1'b1);
    check(32'(act_cnt), 32'h1, "single action");
    rdchk(7'h14, 32'h4, "latched");
    rdchk(7'h11, 32'h0, "cleared");
    rdchk(7'h13, 32'h1, "flag set");
    rdchk(7'h13, 32'h0, "flag cleared");
    act_cnt = 0;
    i_eilac_enc_model.pulse(1'b1);
    check(32'(act_cnt), 32'h0, "disarmed");
    wr(7'h12, 32'h0000_0025);
    act_cnt = 0;
    i_eilac_enc_model.pulse(1'b1);
    check(32'(act_cnt), 32'h0, "A mismatch");
    i_eilac_enc_model.step(3);
    i_eilac_enc_model.pulse(1'b1);
    check(32'(act_cnt), 32'h1, "A B match");
    rdchk(7'h14, 32'h3, "latch only");
    rdchk(7'h11, 32'h3, "kept");
    done("index");
    for (int i = 0; i < 4; i++) begin
      i_eilac_enc_model.set_n(i == 3);
      wr(7'h12, ecfg[i]);
      cyc(4);
      act_cnt = 0;
      i_eilac_enc_model.pulse(i != 3);
      check(32'(act_cnt), 32'(eexp[i]), "edge mode");
    end
    i_eilac_enc_model.set_n(1'b0);
    wr(7'h12, 32'h0000_001C);
    act_cnt = 0;
    i_eilac_enc_model.pulse(1'b1);
    check(32'(act_cnt > 1), 32'h1, "continuous");
    done("edges");
    wr(7'h12, 32'h0);
    match(1'b1);
    wr(7'h12, 32'h0000_1E00);
    match(1'b0);
    compare_position = 32'h3;
    match(1'b1);
    wr(7'h12, 32'h0);
    match(1'b0);
    ramp_position = 32'h3;
    match(1'b1);
    for (int m = 0; m < 2; m++) begin
      wr(7'h12, {18'h0, m[0], 13'h0});
      wr(7'h10, 32'h0000_1388);
      wr(7'h11, 32'h0);
      i_eilac_enc_model.step(3);
      cyc(4);
      rdchk(7'h11, {31'h0, m[0]}, "scaling");
    end
    done("compare_scale");
    wr(7'h17, 32'h0000_0040);
    wr(7'h18, 32'h0);
    for (int r = 0; r < 4; r++) begin
      for (int l = 0; l < 4; l++) begin
        wr(7'h19, 32'((l << 8) | r));
        lim = 8'(64 + 8 * l);
        for (int k = 0; k < 4; k++) begin
          ang = lim - 8'(k[0]);
          if (k[1]) ang = -ang;
          microstep_adr = 13'(ang) << sh[r];
          cyc(4);
          check(32'(load_lead_limit), 32'(k == 0), "lead");
          check(32'(load_lag_limit), 32'(k == 2), "lag");
        end
      end
    end
    wr(7'h17, 32'h0000_0FC0);
    wr(7'h18, 32'h0);
    i_eilac_enc_model.step(2);
    cyc(4);
    rdchk(7'h18, 32'h0000_00FE, "signed step");
    done("vector");
    // Reset again with the encoder parked at a non-zero phase.
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rdchk(7'h11, 32'h0, "position after reset");
    rdchk(7'h18, 32'h0, "angle after reset");
    i_eilac_enc_model.step(2);
    cyc(4);
    rdchk(7'h11, 32'h2, "unit constant after reset");
    rdchk(7'h18, 32'h0, "vector off after reset");
    done("reset_again");
    give_verdict();
  end
endmodule : eilac_top_tb_top
`default_nettype wire
